// ===== hdl/apo_pkg.sv
package apo_pkg;
   // register addresses
   localparam logic [7:0] ADDR_REG_SHORT   = 8'h1F;
   localparam logic [7:0] ADDR_UV_SEL      = 8'h20;
   localparam logic [7:0] ADDR_LINE_TEST   = 8'h21;
   localparam logic [7:0] ADDR_OVR_A       = 8'h22;
   localparam logic [7:0] ADDR_OVR_B       = 8'h23;
   localparam logic [7:0] ADDR_STATE_A     = 8'h24;
   localparam logic [7:0] ADDR_STATE_B     = 8'h25;
   localparam logic [7:0] ADDR_IRQ_STATUS  = 8'h30;
   localparam logic [7:0] ADDR_IRQ_MASK    = 8'h31;
   // field positions
   localparam int POS_SHORT_POLICY = 0;
   localparam int POS_SHORT_FLAG   = 4;
   localparam int POS_UV_REF       = 0;
   localparam int POS_UV_THR       = 1;
   localparam int POS_SLEW_B1      = 0;
   localparam int POS_SLEW_B0      = 1;
   localparam int POS_LOAD_B1      = 2;
   localparam int POS_LOAD_B0      = 3;
   localparam int NUM_A            = 6;
   localparam int NUM_B            = 8;
   // interrupt status bits
   localparam int POS_IRQ_SHORT_ON  = 0;
   localparam int POS_IRQ_SHORT_OFF = 1;
   // reset values
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam logic [7:0] RST_LINE_TEST = 8'h03;
endpackage : apo_pkg

// ===== hdl/apo_reg8.sv
`timescale 1ns/1ps
`default_nettype none
// one software-writable 8-bit register
module apo_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output var  logic [7:0] q
);
   logic [7:0] q_ff;
   // store on write strobe
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) q_ff <= RESET_VAL;
      else if (wr_en) q_ff <= wr_data;
   end
   assign q = q_ff;
endmodule : apo_reg8
`default_nettype wire

// ===== hdl/apo_pwr_sel.sv
`timescale 1ns/1ps
`default_nettype none
// per-block power enable: forced state under override, else sequencer
module apo_pwr_sel #(
   parameter int N = 8
) (
   input  wire logic         mclk,
   input  wire logic         reset_n,
   input  wire logic [N-1:0] ovr,
   input  wire logic [N-1:0] forced,
   input  wire logic [N-1:0] seq_en,
   output var  logic [N-1:0] pwr_en
);
   logic [N-1:0] pwr_ff;
   logic [N-1:0] nxt_pwr;
   assign nxt_pwr = (ovr & forced) | (~ovr & seq_en);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) pwr_ff <= '0;
      else pwr_ff <= nxt_pwr;
   end
   assign pwr_en = pwr_ff;
endmodule : apo_pwr_sel
`default_nettype wire

// ===== hdl/apo_regs.sv
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - policy bit 0 clear: regulator powers down on short; set: no auto power-down
// - short flag bit 4 reads 0 while shorted, 1 otherwise
// - threshold bit 1 selects 0.7/0.3 or 0.67/0.33 of DVDD
// - reference bit 0 selects divided regulator or bandgap; resets 0
// - bits 3,2 are load control bits 0,1; reset 0
// - bits 1,0 are slew control; reset 1
// - override A bits 5..0 for bias ref and left path blocks
// - state A bits 5..0 force power state of same blocks
// - override B bits 7..0 for gain, mute, pump, cal, short, impedance
// - impedance-whole override governs sensing during whole analog power-down
// - state B holds forced state for override B blocks
module apo_regs (
   input  wire logic       mclk,
   input  wire logic       reset_n,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr,
   input  wire logic       rd,
   output var  logic [7:0] rdata,
   input  wire logic       short_detect,
   input  wire logic       whole_pd,
   input  wire logic [5:0] seq_en_a,
   input  wire logic [7:0] seq_en_b,
   output var  logic       reg_pwr_en,
   output var  logic       uv_threshold_select,
   output var  logic       uv_reference_select,
   output var  logic [1:0] line_load_ctrl,
   output var  logic [1:0] line_slew_ctrl,
   output var  logic [5:0] pwr_en_a,
   output var  logic [7:0] pwr_en_b,
   output var  logic       irq
);
   logic [7:0] short_q, uv_q, line_q, ovr_a_q, ovr_b_q, st_a_q, st_b_q, mask_q;
   logic [7:0] rdata_ff, nxt_rdata;
   logic [1:0] irq_st_ff, nxt_irq_st;
   logic       irq_ff, reg_pwr_ff, uv_thr_ff, uv_ref_ff;
   logic [1:0] load_ff, slew_ff;
   logic       short_d_ff, shorted_ff;
   logic [7:0] short_rd;
   logic [7:0] ovr_b_eff;
   logic       nxt_shorted;
   logic       rise, fall;

   // address decode
   wire w_short = wr && addr == apo_pkg::ADDR_REG_SHORT;
   wire w_uv    = wr && addr == apo_pkg::ADDR_UV_SEL;
   wire w_line  = wr && addr == apo_pkg::ADDR_LINE_TEST;
   wire w_ova   = wr && addr == apo_pkg::ADDR_OVR_A;
   wire w_ovb   = wr && addr == apo_pkg::ADDR_OVR_B;
   wire w_sta   = wr && addr == apo_pkg::ADDR_STATE_A;
   wire w_stb   = wr && addr == apo_pkg::ADDR_STATE_B;
   wire w_mask  = wr && addr == apo_pkg::ADDR_IRQ_MASK;
   wire r_stat  = rd && addr == apo_pkg::ADDR_IRQ_STATUS;

   // storage registers, reserved bits kept as plain storage
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_ZERO)) u_short (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_short), .wr_data(wdata), .q(short_q));
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_ZERO)) u_uv (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_uv), .wr_data(wdata), .q(uv_q));
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_LINE_TEST)) u_line (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_line), .wr_data(wdata), .q(line_q));
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_ZERO)) u_ova (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_ova), .wr_data(wdata), .q(ovr_a_q));
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_ZERO)) u_ovb (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_ovb), .wr_data(wdata), .q(ovr_b_q));
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_ZERO)) u_sta (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_sta), .wr_data(wdata), .q(st_a_q));
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_ZERO)) u_stb (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_stb), .wr_data(wdata), .q(st_b_q));
   apo_reg8 #(.RESET_VAL(apo_pkg::RST_ZERO)) u_mask (
      .mclk(mclk), .reset_n(reset_n), .wr_en(w_mask), .wr_data(wdata), .q(mask_q));

   // short flag reads inverted live state; bit 4 not software storage
   always_comb begin
      short_rd = short_q;
      short_rd[apo_pkg::POS_SHORT_FLAG] = ~shorted_ff;
   end

   // read mux
   always_comb begin
      case (addr)
         apo_pkg::ADDR_REG_SHORT:  nxt_rdata = short_rd;
         apo_pkg::ADDR_UV_SEL:     nxt_rdata = uv_q;
         apo_pkg::ADDR_LINE_TEST:  nxt_rdata = line_q;
         apo_pkg::ADDR_OVR_A:      nxt_rdata = ovr_a_q;
         apo_pkg::ADDR_OVR_B:      nxt_rdata = ovr_b_q;
         apo_pkg::ADDR_STATE_A:    nxt_rdata = st_a_q;
         apo_pkg::ADDR_STATE_B:    nxt_rdata = st_b_q;
         apo_pkg::ADDR_IRQ_STATUS: nxt_rdata = {6'h00, irq_st_ff};
         apo_pkg::ADDR_IRQ_MASK:   nxt_rdata = mask_q;
         default:                  nxt_rdata = 8'h00;
      endcase
   end

   // read data register, one cycle after strobe, zero otherwise
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) rdata_ff <= 8'h00;
      else rdata_ff <= rd ? nxt_rdata : 8'h00;
   end

   // short detection edges
   assign nxt_shorted = short_detect;
   assign rise = nxt_shorted & ~short_d_ff;
   assign fall = ~nxt_shorted & short_d_ff;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         short_d_ff <= 1'b0;
         shorted_ff <= 1'b0;
      end else begin
         short_d_ff <= nxt_shorted;
         shorted_ff <= nxt_shorted;
      end
   end

   // sticky status: set wins over read-clear
   always_comb begin
      nxt_irq_st = r_stat ? 2'b00 : irq_st_ff;
      if (rise) nxt_irq_st[apo_pkg::POS_IRQ_SHORT_ON] = 1'b1;
      if (fall) nxt_irq_st[apo_pkg::POS_IRQ_SHORT_OFF] = 1'b1;
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         irq_st_ff <= 2'b00;
         irq_ff    <= 1'b0;
      end else begin
         irq_st_ff <= nxt_irq_st;
         irq_ff    <= |(nxt_irq_st & mask_q[1:0]);
      end
   end

   // regulator stays on unless shorted with auto power-down allowed
   wire nxt_reg_pwr = ~(shorted_ff & ~short_q[apo_pkg::POS_SHORT_POLICY]);
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) reg_pwr_ff <= 1'b1;
      else reg_pwr_ff <= nxt_reg_pwr;
   end

   // analog test selections registered to outputs
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         uv_thr_ff <= 1'b0;
         uv_ref_ff <= 1'b0;
         load_ff   <= 2'b00;
         slew_ff   <= 2'b11;
      end else begin
         uv_thr_ff <= uv_q[apo_pkg::POS_UV_THR];
         uv_ref_ff <= uv_q[apo_pkg::POS_UV_REF];
         load_ff   <= {line_q[apo_pkg::POS_LOAD_B1], line_q[apo_pkg::POS_LOAD_B0]};
         slew_ff   <= {line_q[apo_pkg::POS_SLEW_B1], line_q[apo_pkg::POS_SLEW_B0]};
      end
   end

   // impedance-whole override replaces sense override during whole power-down
   always_comb begin
      ovr_b_eff = ovr_b_q;
      if (whole_pd) ovr_b_eff[1] = ovr_b_q[0];
      if (whole_pd) ovr_b_eff[0] = ovr_b_q[0];
   end

   apo_pwr_sel #(.N(apo_pkg::NUM_A)) u_sel_a (
      .mclk(mclk), .reset_n(reset_n), .ovr(ovr_a_q[5:0]), .forced(st_a_q[5:0]),
      .seq_en(seq_en_a), .pwr_en(pwr_en_a));
   apo_pwr_sel #(.N(apo_pkg::NUM_B)) u_sel_b (
      .mclk(mclk), .reset_n(reset_n), .ovr(ovr_b_eff),
      .forced(whole_pd ? {st_b_q[7:2], st_b_q[0], st_b_q[0]} : st_b_q),
      .seq_en(seq_en_b), .pwr_en(pwr_en_b));

   assign rdata               = rdata_ff;
   assign irq                 = irq_ff;
   assign reg_pwr_en          = reg_pwr_ff;
   assign uv_threshold_select = uv_thr_ff;
   assign uv_reference_select = uv_ref_ff;
   assign line_load_ctrl      = load_ff;
   assign line_slew_ctrl      = slew_ff;
endmodule : apo_regs
`default_nettype wire

// ===== verification/apo_regs_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module apo_regs_asserts (
   input wire logic       mclk,
   input wire logic       reset_n,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] rdata,
   input wire logic       short_detect,
   input wire logic       whole_pd,
   input wire logic [5:0] seq_en_a,
   input wire logic [7:0] seq_en_b,
   input wire logic       reg_pwr_en,
   input wire logic       uv_threshold_select,
   input wire logic       uv_reference_select,
   input wire logic [1:0] line_load_ctrl,
   input wire logic [1:0] line_slew_ctrl,
   input wire logic [5:0] pwr_en_a,
   input wire logic [7:0] pwr_en_b,
   input wire logic       irq
);
   logic [7:0] oa_ff, sa_ff, ob_ff, sb_ff;
   logic       pol_ff, msk_ff, up_ff;
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   // shadow of written controls
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         {oa_ff, sa_ff, ob_ff, sb_ff, pol_ff, msk_ff, up_ff} <= '0;
      end else begin
         up_ff <= 1'b1;
         if (wr && addr == apo_pkg::ADDR_OVR_A) oa_ff <= wdata;
         if (wr && addr == apo_pkg::ADDR_STATE_A) sa_ff <= wdata;
         if (wr && addr == apo_pkg::ADDR_OVR_B) ob_ff <= wdata;
         if (wr && addr == apo_pkg::ADDR_STATE_B) sb_ff <= wdata;
         if (wr && addr == apo_pkg::ADDR_REG_SHORT) pol_ff <= wdata[0];
         if (wr && addr == apo_pkg::ADDR_IRQ_MASK) msk_ff <= wdata[0];
      end
   end
   // expected enables, impedance sense borrows whole bits
   wire logic [5:0] exp_a = (oa_ff[5:0] & sa_ff[5:0]) | (~oa_ff[5:0] & seq_en_a);
   wire logic [7:0] ovb   = whole_pd ? {ob_ff[7:2], ob_ff[0], ob_ff[0]} : ob_ff;
   wire logic [7:0] stb   = whole_pd ? {sb_ff[7:2], sb_ff[0], sb_ff[0]} : sb_ff;
   wire logic [7:0] exp_b = (ovb & stb) | (~ovb & seq_en_b);
   chk_pwr_a_sel: assert property (up_ff |-> pwr_en_a == $past(exp_a))
      else $error("pwr_en_a wrong");
   chk_pwr_b_sel: assert property (up_ff |-> pwr_en_b == $past(exp_b))
      else $error("pwr_en_b wrong");
   chk_short_off: assert property ((short_detect && !pol_ff)[*3] |-> !reg_pwr_en)
      else $error("regulator not shut");
   chk_short_keep: assert property ((!short_detect || pol_ff)[*3] |-> reg_pwr_en)
      else $error("regulator shut");
   chk_line_bits: assert property (wr && addr == apo_pkg::ADDR_LINE_TEST |-> ##2
      line_load_ctrl == $past({wdata[2], wdata[3]}, 2) && line_slew_ctrl == $past({wdata[0], wdata[1]}, 2))
      else $error("line ctrl wrong");
   chk_uv_bits: assert property (wr && addr == apo_pkg::ADDR_UV_SEL |-> ##2
      {uv_threshold_select, uv_reference_select} == $past(wdata[1:0], 2))
      else $error("uv select wrong");
   chk_flag_low: assert property (rd && addr == apo_pkg::ADDR_REG_SHORT && short_detect
      && $past(short_detect) |=> !rdata[4])
      else $error("short flag wrong");
   chk_rdata_idle: assert property (!rd |=> rdata == 8'h00)
      else $error("rdata not idle");
   chk_irq_rise: assert property ($rose(short_detect) && msk_ff |-> ##[1:3] irq)
      else $error("irq missing");
endmodule : apo_regs_asserts
bind apo_regs apo_regs_asserts apo_regs_asserts_i (.*);
`default_nettype wire

// ===== verification/apo_regs_test.sv
`timescale 1ns/1ps
`default_nettype none
module apo_regs_test;
   logic       mclk, reset_n, wr, rd, short_detect, whole_pd, irq;
   logic       reg_pwr_en, uv_threshold_select, uv_reference_select;
   logic [1:0] line_load_ctrl, line_slew_ctrl;
   logic [5:0] seq_en_a, pwr_en_a;
   logic [7:0] addr, wdata, rdata, seq_en_b, pwr_en_b, m;
   int         error_cnt, tests_run;
   logic [7:0] rst_v [7] = '{8'h10, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
   apo_regs apo_regs_i (.*);
   // clock
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 chk(rdata, e);
   endtask : rd_chk
   task automatic settle;
      repeat (4) @(posedge mclk);
      #1;
   endtask : settle
   function automatic logic [7:0] sel(input logic [7:0] o, input logic [7:0] s, input logic [7:0] q);
      return (o & s) | (~o & q);
   endfunction : sel
   task automatic complete_run;
      $display("errors %0d checks %0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : complete_run
   // watchdog
   initial begin
      #20000;
      error_cnt++;
      complete_run;
   end
   // main sequence
   initial begin
      {wr, rd, short_detect, whole_pd, addr, wdata} = '0;
      seq_en_a = 6'h2A;
      seq_en_b = 8'h5A;
      reset_n  = 1'b0;
      repeat (6) @(posedge mclk);
      reset_n <= 1'b1;
      foreach (rst_v[i]) rd_chk(8'h1F + 8'(i), rst_v[i]);
      chk({1'b0, reg_pwr_en, uv_threshold_select, uv_reference_select, line_load_ctrl, line_slew_ctrl}, 8'h43);
      for (int i = 0; i < 8; i++) wr_reg(8'h1F + 8'(i), 8'hA5);
      for (int i = 0; i < 8; i++) rd_chk(8'h1F + 8'(i), i == 0 ? 8'hB5 : i == 7 ? 8'h00 : 8'hA5);
      settle;
      chk({1'b0, reg_pwr_en, uv_threshold_select, uv_reference_select, line_load_ctrl, line_slew_ctrl}, 8'h5A);
      chk({2'b00, pwr_en_a}, sel(8'h25, 8'h25, {2'b00, seq_en_a}));
      for (int w = 0; w < 2; w++) begin
         @(posedge mclk) whole_pd <= w[0];
         settle;
         m = w ? 8'hA7 : 8'hA5;
         chk(pwr_en_b, sel(m, m, seq_en_b));
      end
      wr_reg(8'h24, 8'h00);
      settle;
      chk({2'b00, pwr_en_a}, sel(8'h25, 8'h00, {2'b00, seq_en_a}));
      @(posedge mclk) short_detect <= 1'b1;
      settle;
      chk({7'h00, reg_pwr_en}, 8'h01);
      rd_chk(8'h1F, 8'hA5);
      wr_reg(8'h1F, 8'h00);
      settle;
      chk({6'h00, reg_pwr_en, irq}, 8'h00);
      @(posedge mclk) short_detect <= 1'b0;
      settle;
      chk({7'h00, reg_pwr_en}, 8'h01);
      wr_reg(8'h31, 8'h03);
      settle;
      chk({7'h00, irq}, 8'h01);
      rd_chk(8'h30, 8'h03);
      settle;
      chk({7'h00, irq}, 8'h00);
      @(posedge mclk) short_detect <= 1'b1;
      settle;
      chk({7'h00, irq}, 8'h01);
      rd_chk(8'h30, 8'h01);
      complete_run;
   end
endmodule : apo_regs_test
`default_nettype wire
